/* File: tb.sv */
// self-checking bench for the three-wire serial port in master mode.
// assumes tws_peer on the link; inputs change on falling clock edges.
`timescale 1ns/100ps

module tb;
  logic       clock, link_clock, reset_n, shift_write, ram_write, slow;
  logic [7:0] mode, stat, trig, ival, wdata, ram_wdata;
  logic [4:0] ep, ram_addr;
  wire  [4:0] addr_cnt;
  wire  [7:0] rdata, ram_rdata, got, chk, frames, stb_cnt;
  wire        active, irq, ram_wait, sck_o, sck_oe_n, so, so_oe_n, sin, stb_o, stb_oe_n, busy, lead;
  wire        sck = sck_oe_n ? 1'b1 : sck_o;
  wire        stb = stb_oe_n ? 1'b0 : stb_o;
  int         fails = 0;
  int         comparisons = 0;

  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  initial begin
    link_clock = 0;
    #7;
    forever #16 link_clock = ~link_clock;
  end

  tws_serial_port tws_serial_port_inst (.clock(clock), .reset_n(reset_n), .link_clock(link_clock),
    .serial_mode_reg(mode), .serial_status_reg(stat), .serial_trigger_reg(trig), .byte_interval_reg(ival),
    .end_point_reg(ep), .shift_write(shift_write), .shift_wdata(wdata), .shift_rdata(rdata),
    .transfer_active_flag(active), .transfer_done_irq(irq), .buffer_address_counter(addr_cnt), .ram_write(ram_write),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ram_wait(ram_wait),
    .serial_clock_out(sck_o), .serial_clock_oe_n(sck_oe_n), .serial_clock_in(sck), .serial_out_pin(so),
    .serial_out_oe_n(so_oe_n), .serial_in_pin(sin), .strobe_out_pin(stb_o), .strobe_out_oe_n(stb_oe_n),
    .busy_in_pin(busy));
  tws_peer tws_peer_inst (.rst_n(reset_n), .sck(sck), .so(so), .stb(stb), .slow(slow), .sin(sin), .busy(busy),
    .got(got), .chk(chk), .frames(frames), .lead(lead), .stb_cnt(stb_cnt));

  task automatic give_verdict;
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      rev8[i] = d[7 - i];
  endfunction
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
    if (n == lim) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic write_shift(input logic [7:0] d);
    @(negedge clock);
    wdata = d;
    shift_write = 1;
    @(negedge clock);
    shift_write = 0;
  endtask
  // holds the write until the port stops refusing it
  task automatic ram_put(input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clock);
    ram_addr = a;
    ram_wdata = d;
    ram_write = 1;
    while (ram_wait !== 1'b0 && n < 8) begin
      @(negedge clock);
      n++;
    end
    if (n == 8) begin
      fails++;
      give_verdict();
    end
    @(negedge clock);
    ram_write = 0;
  endtask
  task automatic ram_check(input logic [4:0] a, input logic [7:0] exp);
    @(negedge clock);
    ram_addr = a;
    @(negedge clock);
    check("buffer", ram_rdata, exp);
  endtask

  task automatic t_single(input logic lsb, input logic rpt, input logic [7:0] d);
    logic [7:0] f0;
    f0 = frames;
    @(negedge clock);
    mode = 8'h9c | (lsb ? 8'h02 : 8'h00) | (rpt ? 8'h20 : 8'h00);
    write_shift(d);
    write_shift(~d);
    wait_irq(800);
    check("active", active, 8'h00);
    check("sent", got, lsb ? rev8(d) : d);
    check("lead", lead, 8'h00);
    check("received", rdata, lsb ? rev8(8'h96 ^ f0) : 8'h96 ^ f0);
    repeat (200) @(negedge clock);
    check("frames", frames, f0 + 8'h01);
  endtask
  task automatic t_late;
    logic [7:0] f0;
    f0 = frames;
    @(negedge clock);
    mode = 8'h1c;
    write_shift(8'h5a);
    mode = 8'h9c;
    repeat (100) @(negedge clock);
    check("late active", active, 8'h00);
    check("late frames", frames, f0);
  endtask
  task automatic t_oneway;
    logic [7:0] f0;
    f0 = frames;
    @(negedge clock);
    mode = 8'h98;
    write_shift(8'h3c);
    wait_irq(800);
    check("tx only", rdata, 8'h00);
    check("tx only sent", got, 8'h3c);
    @(negedge clock);
    mode = 8'h94;
    write_shift(8'h00);
    repeat (20) @(negedge clock);
    check("rx only pin", so_oe_n, 8'h01);
    wait_irq(800);
    check("rx only", rdata, 8'h96 ^ (f0 + 8'h01));
  endtask
  task automatic t_auto;
    logic [7:0] c;
    logic [7:0] f0;
    c = chk;
    f0 = frames;
    for (int i = 0; i < 4; i++)
      ram_put(5'(i), 8'h50 + 8'(i));
    ep = 5'h03;
    stat = 8'h30;
    ival = 8'h03;
    slow = 1;
    @(negedge clock);
    mode = 8'hdc;
    @(negedge clock);
    trig = 8'h01;
    @(negedge clock);
    trig = 8'h00;
    ram_put(5'h1f, 8'h77);
    wait_irq(3000);
    for (int i = 0; i < 4; i++)
      c = {c[6:0], c[7]} ^ (8'h50 + 8'(i));
    check("stream", chk, c);
    check("count", frames, f0 + 8'h04);
    check("strobes", stb_cnt, 8'h04);
    check("address", {3'h0, addr_cnt}, 8'h03);
    for (int i = 0; i < 4; i++)
      ram_check(5'(i), 8'h96 ^ (f0 + 8'(i)));
    ram_check(5'h1f, 8'h77);
  endtask
  task automatic t_disable;
    @(negedge clock);
    mode = 8'h9c;
    write_shift(8'ha5);
    repeat (20) @(negedge clock);
    mode = 8'h1c;
    @(negedge clock);
    check("stopped", {active, irq}, 8'h00);
    repeat (10) @(negedge clock);
    check("released", {sck_oe_n, so_oe_n, stb_oe_n}, 8'h07);
  endtask

  initial begin
    {reset_n, shift_write, ram_write, slow} = '0;
    {mode, stat, trig, ival, wdata, ram_wdata, ep, ram_addr} = '0;
    repeat (4) @(negedge clock);
    reset_n = 1;
    repeat (6) @(negedge clock);
    t_single(1'b0, 1'b0, 8'h35);
    t_single(1'b1, 1'b1, 8'hc6);
    t_late();
    t_oneway();
    t_auto();
    t_disable();
    give_verdict();
  end
endmodule // tb

/* File: tws_map.svh */
// constants of the three-wire serial port with automatic transfer:
// bit positions of the control words, buffer geometry and handshake gaps.
// included by the design; holds definitions only.
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

// serial_mode_reg bit positions
`define TWS_MODE_ENABLE    7
`define TWS_MODE_AUTO      6
`define TWS_MODE_REPEAT    5
`define TWS_MODE_MASTER    4
`define TWS_MODE_TX_EN     3
`define TWS_MODE_RX_EN     2
`define TWS_MODE_ORDER     1

// serial_status_reg bit positions
`define TWS_STAT_STROBE_EN 5
`define TWS_STAT_BUSY_EN   4
`define TWS_STAT_ACTIVE    0

// serial_trigger_reg bit position
`define TWS_TRIG_START     0

// transfer geometry
`define TWS_BYTE_BITS      8
`define TWS_RAM_DEPTH      32
`define TWS_RAM_FIRST      16'hfa00
`define TWS_RAM_LAST       16'hfa1f

// least inter-byte gap, in serial clocks, forced by the handshakes
`define TWS_STROBE_GAP     6'h02
`define TWS_BUSY_GAP       6'h01

// link clock cycles per serial clock half period in master mode
`define TWS_SCK_HALF       4

`endif

/* File: tws_peer.sv */
// behavioural peripheral on the far side of the serial link.
// assumes a master-driven serial clock idling high; replies 8'h96 ^ frame index.
`timescale 1ns/100ps

module tws_peer (
  input  wire logic       rst_n,
  input  wire logic       sck,
  input  wire logic       so,
  input  wire logic       stb,
  input  wire logic       slow,
  output logic            sin,
  output logic            busy,
  output logic      [7:0] got,
  output logic      [7:0] chk,
  output logic      [7:0] frames,
  output logic            lead,
  output logic      [7:0] stb_cnt
);
  logic [7:0] rx;
  logic [7:0] tx;
  wire        so_d;
  int         cnt;
  // delayed copy shows the level just before the falling edge moved it
  assign #5 so_d = so;
  assign tx = 8'h96 ^ frames;
  initial begin
    {sin, busy, got, chk, frames, lead, stb_cnt, rx, cnt} = '0;
  end
  always @(negedge sck) begin
    if (cnt == 0)
      lead = so_d;
    sin = tx[7 - cnt];
  end
  always @(posedge sck) begin
    if (!rst_n)
      cnt = 0;
    else begin
      rx = {rx[6:0], so};
      cnt = cnt + 1;
      if (cnt == 8) begin
        cnt = 0;
        got = rx;
        chk = {chk[6:0], chk[7]} ^ rx;
        frames = frames + 8'h01;
        // no stale bit left on the line between frames
        sin = ~sin;
        if (slow)
          busy = 1'b1;
      end
    end
  end
  always @(posedge busy) begin
    #700;
    busy = 1'b0;
  end
  always @(posedge stb)
    stb_cnt = stb_cnt + 8'h01;
endmodule // tws_peer

/* File: tws_pkg.sv */
// types shared by the three-wire serial port: state encodings and the
// request bundle handed from the system clock side to the link side.
package tws_pkg;

  typedef enum logic [2:0] {
    TWS_C_IDLE  = 3'h0,
    TWS_C_LOAD  = 3'h1,
    TWS_C_REQ   = 3'h3,
    TWS_C_DROP  = 3'h2,
    TWS_C_WRITE = 3'h6
  } tws_cpu_state_e;

  typedef enum logic [1:0] {
    TWS_L_IDLE  = 2'h0,
    TWS_L_SHIFT = 2'h1,
    TWS_L_GAP   = 2'h3,
    TWS_L_ACK   = 2'h2
  } tws_link_state_e;

  // held stable by the sender for as long as the request level is high
  typedef struct packed {
    logic [7:0] data;
    logic       tx_en;
    logic       rx_en;
    logic       paced;
    logic       strobe_en;
    logic       busy_en;
    logic [5:0] interval;
  } tws_req_s;

endpackage

/* File: tws_serial_port.sv */
// three-wire clocked serial port with single-byte and automatic buffer transfers.
// assumes: clock is the system clock, link_clock runs the serial side (bit timing
// source in master mode), control bits arrive as plain ports, pins are resolved outside.
//
// Summary of operation
// - enabled, non-automatic: shift register write launches a byte, out on fall, captured rise.
// - transmit and receive bits move in the same byte transfer.
// - each completed single-byte exchange raises the transfer-done request.
// - repeat bit has no effect in single-byte mode.
// - a shift register write that starts a byte with transmit enabled drives the serial output pin low.
// - every transfer is eight bits; mode bit 1 picks MSB or LSB first.
// - bit order is applied by reversing data at write and read time, shift direction fixed.
// - write starts only when enabled and no transfer is running.
// - enabling after the data write starts nothing.
// - after eight bits a single-byte transfer stops itself and raises its request; automatic mode goes on to the next buffer byte.
// - automatic mode moves the configured count of up to 32 buffer bytes.
// - automatic transfers drive a strobe and watch a busy input.
// - strobe and busy pins serve the port only in automatic master mode with both enabled.
// - enable cleared stops shifting, clears clock counting, releases all pins.
// - port buffer writes may stall a concurrent buffer write from outside.
// - buffer address counts up per byte, stops at end point or wraps in repeat.
// - the inter-byte interval is programmable from 0 to 63 serial clocks in master mode; slave mode forces it to 0.
`timescale 1ns/100ps
`include "tws_map.svh"

module tws_serial_port
  import tws_pkg::*;
#(
  parameter int SCK_HALF  = `TWS_SCK_HALF,
  parameter int RAM_DEPTH = `TWS_RAM_DEPTH
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       link_clock,
  input  wire logic [7:0] serial_mode_reg,
  input  wire logic [7:0] serial_status_reg,
  input  wire logic [7:0] serial_trigger_reg,
  input  wire logic [7:0] byte_interval_reg,
  input  wire logic [4:0] end_point_reg,
  input  wire logic       shift_write,
  input  wire logic [7:0] shift_wdata,
  output logic      [7:0] shift_rdata,
  output logic            transfer_active_flag,
  output logic            transfer_done_irq,
  output logic      [4:0] buffer_address_counter,
  input  wire logic       ram_write,
  input  wire logic [4:0] ram_addr,
  input  wire logic [7:0] ram_wdata,
  output logic      [7:0] ram_rdata,
  output logic            ram_wait,
  output logic            serial_clock_out,
  output logic            serial_clock_oe_n,
  input  wire logic       serial_clock_in,
  output logic            serial_out_pin,
  output logic            serial_out_oe_n,
  input  wire logic       serial_in_pin,
  output logic            strobe_out_pin,
  output logic            strobe_out_oe_n,
  input  wire logic       busy_in_pin
);

  localparam int GAP_W = 16;
  localparam logic [GAP_W-1:0] SER_CYC = GAP_W'(2 * SCK_HALF);
  localparam logic [7:0]       HALF_LAST = 8'(SCK_HALF - 1);

  logic [7:0] ram [RAM_DEPTH];

  // ---------------- system clock side ----------------
  tws_cpu_state_e state, next_state;
  tws_req_s       req_data, next_req_data;
  logic           req, next_req;
  logic [7:0]     shift_reg, next_shift_reg;
  logic           active, next_active;
  logic           irq, next_irq;
  logic [4:0]     addr, next_addr;
  logic           wait_q, next_wait;
  logic           ack_c1, ack_c2;
  logic           link_ack, next_link_ack;
  logic [7:0]     link_rx;

  logic       port_en, auto_mode, repeat_mode, master, order_lsb;
  logic [7:0] wdata_rev, ram_rev, shift_rev, tx_pick;
  logic       single_go, auto_go;

  assign port_en     = serial_mode_reg[`TWS_MODE_ENABLE];
  assign auto_mode   = serial_mode_reg[`TWS_MODE_AUTO];
  assign repeat_mode = serial_mode_reg[`TWS_MODE_REPEAT];
  assign master      = serial_mode_reg[`TWS_MODE_MASTER];
  assign order_lsb   = serial_mode_reg[`TWS_MODE_ORDER];

  // fixed wiring reversal: the shifter always sends bit 7 first
  for (genvar i = 0; i < `TWS_BYTE_BITS; i++) begin : g_rev
    assign wdata_rev[i] = shift_wdata[7-i];
    assign ram_rev[i]   = ram[addr][7-i];
    assign shift_rev[i] = shift_reg[7-i];
  end

  assign single_go = shift_write && port_en && !auto_mode && !active && !ack_c2;
  assign auto_go   = serial_trigger_reg[`TWS_TRIG_START] && port_en && auto_mode && !active && !ack_c2;
  assign tx_pick   = order_lsb ? ram_rev : ram[addr];

  always_comb begin
    next_state     = state;
    next_req_data  = req_data;
    next_req       = req;
    next_shift_reg = shift_reg;
    next_active    = active;
    next_irq       = 1'b0;
    next_addr      = addr;
    // a write with the port idle stores data even if disabled, but starts nothing
    if (shift_write && !active) begin
      next_shift_reg = order_lsb ? wdata_rev : shift_wdata;
    end
    next_req_data.tx_en     = serial_mode_reg[`TWS_MODE_TX_EN];
    next_req_data.rx_en     = serial_mode_reg[`TWS_MODE_RX_EN];
    next_req_data.paced     = auto_mode && master;
    next_req_data.strobe_en = serial_status_reg[`TWS_STAT_STROBE_EN];
    next_req_data.busy_en   = serial_status_reg[`TWS_STAT_BUSY_EN];
    next_req_data.interval  = master ? byte_interval_reg[5:0] : 6'h00;
    if (req) begin
      next_req_data = req_data;
    end
    case (state)
      TWS_C_IDLE: begin
        if (single_go) begin
          next_req_data.data = order_lsb ? wdata_rev : shift_wdata;
          next_req           = 1'b1;
          next_active        = 1'b1;
          next_state         = TWS_C_REQ;
        end else if (auto_go) begin
          next_addr   = 5'h00;
          next_active = 1'b1;
          next_state  = TWS_C_LOAD;
        end
      end
      TWS_C_LOAD: begin
        next_req_data.data = tx_pick;
        next_req           = 1'b1;
        next_state         = TWS_C_REQ;
      end
      TWS_C_REQ: begin
        if (ack_c2) begin
          next_shift_reg = link_rx;
          next_req       = 1'b0;
          next_state     = TWS_C_DROP;
        end
      end
      TWS_C_DROP: begin
        if (!ack_c2) begin
          if (auto_mode) begin
            next_state = TWS_C_WRITE;
          end else begin
            next_active = 1'b0;
            next_irq    = 1'b1;
            next_state  = TWS_C_IDLE;
          end
        end
      end
      TWS_C_WRITE: begin
        if (addr == end_point_reg) begin
          if (repeat_mode) begin
            next_addr  = 5'h00;
            next_state = TWS_C_LOAD;
          end else begin
            next_active = 1'b0;
            next_irq    = 1'b1;
            next_state  = TWS_C_IDLE;
          end
        end else begin
          next_addr  = addr + 5'h01;
          next_state = TWS_C_LOAD;
        end
      end
      default: begin
        next_state = TWS_C_IDLE;
      end
    endcase
    // disabling drops state, request, active and done request; the link side clears itself from the same bit
    if (!port_en) begin
      next_state  = TWS_C_IDLE;
      next_req    = 1'b0;
      next_active = 1'b0;
      next_irq    = 1'b0;
    end
    // the buffer port belongs to the shifter for the one write cycle
    next_wait = (next_state == TWS_C_WRITE);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state                  <= TWS_C_IDLE;
      req_data               <= '0;
      req                    <= 1'b0;
      shift_reg              <= 8'h00;
      active                 <= 1'b0;
      irq                    <= 1'b0;
      addr                   <= 5'h00;
      wait_q                 <= 1'b0;
      ack_c1                 <= 1'b0;
      ack_c2                 <= 1'b0;
      shift_rdata            <= 8'h00;
      transfer_active_flag   <= 1'b0;
      transfer_done_irq      <= 1'b0;
      buffer_address_counter <= 5'h00;
      ram_rdata              <= 8'h00;
      ram_wait               <= 1'b0;
    end else begin
      state                  <= next_state;
      req_data               <= next_req_data;
      req                    <= next_req;
      shift_reg              <= next_shift_reg;
      active                 <= next_active;
      irq                    <= next_irq;
      addr                   <= next_addr;
      wait_q                 <= next_wait;
      ack_c1                 <= link_ack;
      ack_c2                 <= ack_c1;
      shift_rdata            <= order_lsb ? shift_rev : shift_reg;
      transfer_active_flag   <= next_active;
      transfer_done_irq      <= next_irq;
      buffer_address_counter <= next_addr;
      ram_rdata              <= ram[ram_addr];
      ram_wait               <= next_wait;
    end
  end

  // outside writes are refused while the shifter owns the write port
  always_ff @(posedge clock) begin
    if (state == TWS_C_WRITE) begin
      ram[addr] <= order_lsb ? shift_rev : shift_reg;
    end else if (ram_write && !wait_q) begin
      ram[ram_addr] <= ram_wdata;
    end
  end

  // ---------------- link clock side ----------------
  tws_link_state_e l_state, next_l_state;
  tws_req_s        cfg, next_cfg;
  logic [7:0]      tx_sh, next_tx_sh, rx_sh, next_rx_sh;
  logic [3:0]      bit_cnt, next_bit_cnt;
  logic [7:0]      half_cnt, next_half_cnt;
  logic [GAP_W-1:0] gap_cnt, next_gap_cnt;
  logic [7:0]      stb_left, next_stb_left;
  logic            sck_drv, next_sck_drv, so, next_so;
  logic            stb, next_stb;
  logic            rst_l1, rst_l2, en_l1, en_l2, mst_l1, mst_l2, req_l1, req_l2;
  logic [2:0]      sck_p, si_p, busy_p;
  logic            sck_lvl, si_lvl, busy_lvl, sck_new, si_new;
  logic            tick, fall, rise, link_clr;
  logic [5:0]      gap_len;

  assign link_rx  = rx_sh;
  assign link_clr = !rst_l2 || !en_l2;
  assign sck_new  = (sck_p[1] == sck_p[2]) ? sck_p[2] : sck_lvl;
  // agreed input level used directly: one more flop would miss the bit driven at the last fall
  assign si_new   = (si_p[1] == si_p[2]) ? si_p[2] : si_lvl;
  assign tick     = (half_cnt == HALF_LAST);
  assign fall     = mst_l2 ? (tick && sck_drv) : (sck_lvl && !sck_new);
  assign rise     = mst_l2 ? (tick && !sck_drv) : (!sck_lvl && sck_new);

  always_comb begin
    gap_len = cfg.interval;
    // handshakes impose their own least gap even with a zero interval
    if (cfg.paced && cfg.strobe_en && gap_len < `TWS_STROBE_GAP) begin
      gap_len = `TWS_STROBE_GAP;
    end else if (cfg.paced && cfg.busy_en && gap_len < `TWS_BUSY_GAP) begin
      gap_len = `TWS_BUSY_GAP;
    end
  end

  always_comb begin
    next_l_state  = l_state;
    next_cfg      = cfg;
    next_link_ack = link_ack;
    next_tx_sh    = tx_sh;
    next_rx_sh    = rx_sh;
    next_bit_cnt  = bit_cnt;
    next_half_cnt = half_cnt;
    next_gap_cnt  = gap_cnt;
    next_stb_left = stb_left;
    next_sck_drv  = sck_drv;
    next_so       = so;
    next_stb      = stb;
    case (l_state)
      TWS_L_IDLE: begin
        next_sck_drv  = 1'b1;
        next_half_cnt = 8'h00;
        if (req_l2 && !link_ack) begin
          next_cfg     = req_data;
          next_tx_sh   = req_data.data;
          next_so      = 1'b0;
          next_bit_cnt = 4'h0;
          next_l_state = TWS_L_SHIFT;
        end
      end
      TWS_L_SHIFT: begin
        next_half_cnt = tick ? 8'h00 : half_cnt + 8'h01;
        if (tick) begin
          next_sck_drv = !sck_drv;
        end
        if (fall) begin
          next_so    = tx_sh[7];
          next_tx_sh = {tx_sh[6:0], 1'b0};
        end
        if (rise) begin
          next_rx_sh   = {rx_sh[6:0], cfg.rx_en & si_new};
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == 4'(`TWS_BYTE_BITS - 1)) begin
            next_gap_cnt  = GAP_W'(gap_len) * SER_CYC;
            next_stb      = cfg.paced && cfg.strobe_en && cfg.busy_en;
            next_stb_left = 8'(SER_CYC);
            next_l_state  = TWS_L_GAP;
          end
        end
      end
      TWS_L_GAP: begin
        next_sck_drv = 1'b1;
        if (gap_cnt != '0) begin
          next_gap_cnt = gap_cnt - GAP_W'(1);
        end
        if (stb_left != 8'h00) begin
          next_stb_left = stb_left - 8'h01;
        end
        if (stb_left == 8'h01) begin
          next_stb = 1'b0;
        end
        if (gap_cnt == '0 && !(cfg.paced && cfg.busy_en && cfg.strobe_en && busy_lvl)) begin
          next_link_ack = 1'b1;
          next_l_state  = TWS_L_ACK;
        end
      end
      TWS_L_ACK: begin
        if (!req_l2) begin
          next_link_ack = 1'b0;
          next_l_state  = TWS_L_IDLE;
        end
      end
      default: begin
        next_l_state = TWS_L_IDLE;
      end
    endcase
    if (link_clr) begin
      next_l_state  = TWS_L_IDLE;
      next_cfg      = '0;
      next_link_ack = 1'b0;
      next_bit_cnt  = 4'h0;
      next_half_cnt = 8'h00;
      next_gap_cnt  = '0;
      next_stb_left = 8'h00;
      next_sck_drv  = 1'b1;
      next_so       = 1'b0;
      next_stb      = 1'b0;
    end
  end

  always_ff @(posedge link_clock) begin
    rst_l1 <= reset_n;
    rst_l2 <= rst_l1;
    en_l1  <= port_en;
    en_l2  <= en_l1;
    mst_l1 <= master;
    mst_l2 <= mst_l1;
    req_l1 <= req;
    req_l2 <= req_l1;
    sck_p  <= {sck_p[1:0], serial_clock_in};
    si_p   <= {si_p[1:0], serial_in_pin};
    busy_p <= {busy_p[1:0], busy_in_pin};
    if (!rst_l2) begin
      l_state           <= TWS_L_IDLE;
      cfg               <= '0;
      link_ack          <= 1'b0;
      tx_sh             <= 8'h00;
      rx_sh             <= 8'h00;
      bit_cnt           <= 4'h0;
      half_cnt          <= 8'h00;
      gap_cnt           <= '0;
      stb_left          <= 8'h00;
      sck_drv           <= 1'b1;
      so                <= 1'b0;
      stb               <= 1'b0;
      sck_lvl           <= 1'b1;
      si_lvl            <= 1'b0;
      busy_lvl          <= 1'b0;
      serial_clock_out  <= 1'b1;
      serial_clock_oe_n <= 1'b1;
      serial_out_pin    <= 1'b0;
      serial_out_oe_n   <= 1'b1;
      strobe_out_pin    <= 1'b0;
      strobe_out_oe_n   <= 1'b1;
    end else begin
      l_state           <= next_l_state;
      cfg               <= next_cfg;
      link_ack          <= next_link_ack;
      tx_sh             <= next_tx_sh;
      rx_sh             <= next_rx_sh;
      bit_cnt           <= next_bit_cnt;
      half_cnt          <= next_half_cnt;
      gap_cnt           <= next_gap_cnt;
      stb_left          <= next_stb_left;
      sck_drv           <= next_sck_drv;
      so                <= next_so;
      stb               <= next_stb;
      sck_lvl           <= sck_new;
      si_lvl            <= si_new;
      busy_lvl          <= (busy_p[1] == busy_p[2]) ? busy_p[2] : busy_lvl;
      serial_clock_out  <= next_sck_drv;
      serial_clock_oe_n <= link_clr || !mst_l2;
      serial_out_pin    <= next_so;
      serial_out_oe_n   <= link_clr || !next_cfg.tx_en;
      strobe_out_pin    <= next_stb;
      strobe_out_oe_n   <= !(next_cfg.paced && next_cfg.strobe_en && next_cfg.busy_en);
    end
  end

endmodule // tws_serial_port

/* File: tws_serial_port_props.sv */
// assertions for the three-wire serial port, bound to its top module.
// assumes the default SCK_HALF and status bits held steady around each transfer.
`timescale 1ns/100ps

module tws_props (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic [7:0] serial_mode_reg,
  input wire logic [7:0] serial_status_reg,
  input wire logic       shift_write,
  input wire logic       transfer_active_flag,
  input wire logic       transfer_done_irq,
  input wire logic       ram_wait,
  input wire logic       serial_clock_oe_n,
  input wire logic       serial_out_oe_n,
  input wire logic       strobe_out_oe_n
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  logic [7:0] m;
  logic       hs;
  assign m  = serial_mode_reg;
  assign hs = m[6] & m[4] & serial_status_reg[5] & serial_status_reg[4];

  done_pulse_a: assert property (transfer_done_irq |=> !transfer_done_irq)
    else $error("done request held past one cycle");
  done_ends_a: assert property (transfer_done_irq |-> !transfer_active_flag && $past(transfer_active_flag))
    else $error("done request not paired with end of activity");
  write_starts_a: assert property (shift_write && m[7] && !m[6] && !transfer_active_flag |=> transfer_active_flag)
    else $error("enabled write did not start a byte");
  off_no_start_a: assert property (shift_write && !m[7] && !transfer_active_flag |=> !transfer_active_flag)
    else $error("write while disabled started a byte");
  off_stops_a: assert property (!m[7] |=> !transfer_active_flag && !transfer_done_irq)
    else $error("disabled port still active");
  off_pins_a: assert property (!m[7] [*4] |-> serial_clock_oe_n && serial_out_oe_n && strobe_out_oe_n)
    else $error("disabled port still drives a pin");
  tx_pin_a: assert property (!m[3] [*6] |-> serial_out_oe_n)
    else $error("serial output driven with transmit off");
  strobe_pin_a: assert property (!hs [*6] |-> strobe_out_oe_n)
    else $error("strobe pin driven outside handshake mode");
  // eight serial clocks of 256 ns each cannot finish in under 38 cycles
  byte_time_a: assert property ($rose(transfer_active_flag) && m[4] && !m[6] |->
    !transfer_done_irq [*8] ##[30:600] (transfer_done_irq || !m[7]))
    else $error("single byte length out of range");
  wait_auto_a: assert property (ram_wait |-> m[6] && transfer_active_flag)
    else $error("buffer wait outside automatic transfer");

  single_done_c: cover property (transfer_done_irq && !m[6]);
  auto_done_c: cover property (transfer_done_irq && m[6]);
  buffer_wait_c: cover property (ram_wait);
endmodule // tws_props

bind tws_serial_port tws_props tws_props_inst (
  .clock(clock), .reset_n(reset_n), .serial_mode_reg(serial_mode_reg), .serial_status_reg(serial_status_reg),
  .shift_write(shift_write), .transfer_active_flag(transfer_active_flag), .transfer_done_irq(transfer_done_irq),
  .ram_wait(ram_wait), .serial_clock_oe_n(serial_clock_oe_n), .serial_out_oe_n(serial_out_oe_n),
  .strobe_out_oe_n(strobe_out_oe_n));
